/* drc_ramp_control.sv */
// drive ramp selection, fan, direction, encoder loss and keypad remapping
`timescale 1ns/1ps
`default_nettype none
module drc_ramp_control #(
  parameter int TICK_CYCLES_P = drc_pkg::TICK_CYCLES,
  parameter int FAN_WAIT_P    = drc_pkg::FAN_WAIT_MS,
  parameter int FAN_LIMIT_P   = drc_pkg::FAN_LIMIT_MS,
  parameter int HOLD_P        = drc_pkg::HOLD_MS
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [4:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // run state and commands
  input  wire logic        running,
  input  wire logic        terminalCtrl,
  input  wire logic        keypadRevRun,
  input  wire logic        reverseRunTerminal,
  input  wire logic        reverseInchTerminal,
  input  wire logic        forcedStop,
  input  wire logic        abnormalStop,
  input  wire logic        seqProgRun,
  input  wire logic        jogRun,
  input  wire logic [15:0] seqAccelTime,
  input  wire logic [15:0] seqDecelTime,
  input  wire logic [15:0] jogAccelTime,
  input  wire logic [15:0] jogDecelTime,
  input  wire logic [1:0]  rampSelTerm,
  input  wire logic        rampSelActive,
  input  wire logic        decelerating,
  input  wire logic        cmdReverse,
  input  wire logic        outReverse,
  input  wire logic [16:0] freqTarget,
  // fan and encoder
  input  wire logic [7:0]  moduleTempC,
  input  wire logic        encoderPulse,
  input  wire logic        encoderUsed,
  // keypad
  input  wire logic        keypadMonitor,
  input  wire logic        functionGroupShown,
  input  wire logic        jogKey,
  input  wire logic        runKey,
  input  wire logic        shiftKey,
  // outputs to the drive
  output logic      [16:0] freqStep,
  output logic      [16:0] freqOut,
  output logic             phaseSwap,
  output logic             runInhibit,
  output logic             fanOn,
  output logic      [1:0]  encoderLossAct,
  output logic             encoderLoss,
  output logic      [23:0] gearedSpeed,
  output logic             jogCmd,
  output logic             dirToggle,
  output logic             upKey,
  output logic             decrementKey,
  output logic             runKeyOut
);
  import drc_pkg::*;

  // register indices
  localparam logic [4:0] A_ACC2 = 5'h00, A_DEC2 = 5'h01, A_ACC3 = 5'h02, A_DEC3 = 5'h03;
  localparam logic [4:0] A_ACC4 = 5'h04, A_DEC4 = 5'h05, A_ABN  = 5'h06, A_MULT = 5'h07;
  localparam logic [4:0] A_FAN  = 5'h08, A_PHS  = 5'h09, A_RLCK = 5'h0A, A_PPR  = 5'h0B;
  localparam logic [4:0] A_LTIM = 5'h0C, A_LACT = 5'h0D, A_MGR  = 5'h0E, A_EGR  = 5'h0F;
  localparam logic [4:0] A_JOGR = 5'h10, A_UPDN = 5'h11, A_FRNG = 5'h12, A_OCAP = 5'h13;
  localparam logic [4:0] A_JPRI = 5'h14, A_ACC1 = 5'h15, A_DEC1 = 5'h16, A_STAT = 5'h17;
  localparam logic [4:0] A_STOP = 5'h18;

  typedef struct packed {
    logic [7:0][15:0] rampTime;   // acc1,dec1,acc2,dec2,acc3,dec3,acc4,dec4
    logic [15:0] abnTime;
    logic [1:0]  mult;
    logic        fanMode;
    logic        phaseOrder;
    logic        revLock;
    logic [13:0] ppr;
    logic [6:0]  lossTime;
    logic [1:0]  lossAct;
    logic [9:0]  motorGear;
    logic [9:0]  encGear;
    logic        jogRole;
    logic        updnSet;
    logic        updnHeld;
    logic        freqRange;
    logic [16:0] oppCap;
    logic        jogPri;
    logic [1:0]  stopMethod;
    logic [15:0] rdData;
    logic [17:0] tickCnt;
    drc_fan_type fanState;
    logic [20:0] fanCnt;
    logic [13:0] lossCnt;
    logic [13:0] holdCnt;
    logic [15:0] pulseCnt;
    logic        jogKeyPrev;
    logic        encPrev;
    logic [16:0] freqStep;
    logic [16:0] freqOut;
    logic        runInhibit;
    logic        fanOn;
    logic        encLoss;
    logic [23:0] geared;
    logic        jogCmd;
    logic        dirToggle;
    logic        upKey;
    logic        dnKey;
    logic        runKeyOut;
  } drc_state_type;

  drc_state_type st, next_st;

  // limit a written ramp time to its legal range
  function automatic logic [15:0] clampRamp(input logic [15:0] v);
    clampRamp = (v < RAMP_MIN) ? RAMP_MIN : ((v > RAMP_MAX) ? RAMP_MAX : v);
  endfunction

  logic [15:0] activeTime;
  logic [19:0] scaledTime;
  logic [16:0] span;
  logic [2:0]  pairIdx;
  logic        tick;
  logic        updnOn;

  always_comb begin
    next_st = st;
    tick = (st.tickCnt == 18'(TICK_CYCLES_P - 1));
    next_st.tickCnt = tick ? 18'h00000 : st.tickCnt + 18'h00001;
    updnOn = st.updnSet | st.updnHeld;

    // register writes
    if (regWr) begin
      if (regAddr <= A_DEC4) begin
        next_st.rampTime[regAddr[2:0] + 3'h2] = clampRamp(regWrData);
      end else if (regAddr == A_ABN) begin
        next_st.abnTime = clampRamp(regWrData);
      end else if (regAddr == A_MULT) begin
        if (regWrData[1:0] != 2'h3) next_st.mult = regWrData[1:0];
      end else if (regAddr == A_FAN) begin
        next_st.fanMode = regWrData[0];
      end else if (regAddr == A_PHS) begin
        next_st.phaseOrder = regWrData[0];
      end else if (regAddr == A_RLCK) begin
        next_st.revLock = regWrData[0];
      end else if (regAddr == A_PPR) begin
        if (regWrData[13:0] != 14'h0000 && regWrData[13:0] <= PPR_MAX) next_st.ppr = regWrData[13:0];
      end else if (regAddr == A_LTIM) begin
        if (regWrData[6:0] <= LOSS_MAX) next_st.lossTime = regWrData[6:0];
      end else if (regAddr == A_LACT) begin
        next_st.lossAct = regWrData[1:0];
      end else if (regAddr == A_MGR) begin
        if (regWrData[9:0] != 10'h000 && regWrData[9:0] <= GEAR_MAX) next_st.motorGear = regWrData[9:0];
      end else if (regAddr == A_EGR) begin
        if (regWrData[9:0] != 10'h000 && regWrData[9:0] <= GEAR_MAX) next_st.encGear = regWrData[9:0];
      end else if (regAddr == A_JOGR) begin
        next_st.jogRole = regWrData[0];
      end else if (regAddr == A_UPDN) begin
        next_st.updnSet = regWrData[0];
      end else if (regAddr == A_FRNG) begin
        next_st.freqRange = regWrData[0];
      end else if (regAddr == A_OCAP) begin
        next_st.oppCap = {1'b0, regWrData};
      end else if (regAddr == A_JPRI) begin
        next_st.jogPri = regWrData[0];
      end else if (regAddr == A_ACC1 || regAddr == A_DEC1) begin
        next_st.rampTime[{2'h0, regAddr == A_DEC1}] = clampRamp(regWrData);
      end else if (regAddr == A_STOP) begin
        next_st.stopMethod = regWrData[1:0];
      end
    end

    // register reads, data valid next cycle
    pairIdx = rampSelActive ? {rampSelTerm, decelerating} : {2'h0, decelerating};
    next_st.rdData = 16'h0000;
    if (regRd) begin
      if (regAddr <= A_DEC4) next_st.rdData = st.rampTime[regAddr[2:0] + 3'h2];
      else if (regAddr == A_ABN) next_st.rdData = st.abnTime;
      else if (regAddr == A_MULT) next_st.rdData = {14'h0000, st.mult};
      else if (regAddr == A_FAN) next_st.rdData = {15'h0000, st.fanMode};
      else if (regAddr == A_PHS) next_st.rdData = {15'h0000, st.phaseOrder};
      else if (regAddr == A_RLCK) next_st.rdData = {15'h0000, st.revLock};
      else if (regAddr == A_PPR) next_st.rdData = {2'h0, st.ppr};
      else if (regAddr == A_LTIM) next_st.rdData = {9'h000, st.lossTime};
      else if (regAddr == A_LACT) next_st.rdData = {14'h0000, st.lossAct};
      else if (regAddr == A_MGR) next_st.rdData = {6'h00, st.motorGear};
      else if (regAddr == A_EGR) next_st.rdData = {6'h00, st.encGear};
      else if (regAddr == A_JOGR) next_st.rdData = {15'h0000, st.jogRole};
      else if (regAddr == A_UPDN) next_st.rdData = {15'h0000, updnOn};
      else if (regAddr == A_FRNG) next_st.rdData = {15'h0000, st.freqRange};
      else if (regAddr == A_OCAP) next_st.rdData = st.oppCap[15:0];
      else if (regAddr == A_JPRI) next_st.rdData = {15'h0000, st.jogPri};
      else if (regAddr == A_ACC1) next_st.rdData = st.rampTime[0];
      else if (regAddr == A_DEC1) next_st.rdData = st.rampTime[1];
      else if (regAddr == A_STAT) next_st.rdData = {11'h000, st.encLoss, st.fanOn, st.runInhibit, pairIdx[2:1]};
      else if (regAddr == A_STOP) next_st.rdData = {14'h0000, st.stopMethod};
    end

    // ramp time source
    activeTime = st.rampTime[pairIdx];
    if (forcedStop || abnormalStop) begin
      activeTime = st.abnTime;
    end else if (jogRun) begin
      activeTime = decelerating ? jogDecelTime : jogAccelTime;
    end else if (seqProgRun) begin
      activeTime = decelerating ? seqDecelTime : seqAccelTime;
    end
    case (st.mult)
      MULT_TEN: scaledTime = {4'h0, activeTime} * 20'h0000A;
      MULT_TENTH: scaledTime = {4'h0, activeTime} / 20'h0000A;
      default: scaledTime = {4'h0, activeTime};
    endcase
    if (scaledTime == 20'h00000) scaledTime = 20'h00001;
    // step per 1 ms tick: span / (time in 0.1 s * 100 ticks)
    span = st.freqRange ? SPAN_HIGH : SPAN_LOW;
    next_st.freqStep = 17'((32'(span) + 32'(scaledTime) * 32'd100 - 32'd1) / (32'(scaledTime) * 32'd100));

    // output frequency limits and reverse handling
    next_st.freqOut = (freqTarget > span) ? span : freqTarget;
    if (outReverse != cmdReverse && next_st.freqOut > st.oppCap) next_st.freqOut = st.oppCap;
    if (st.revLock && !terminalCtrl && keypadRevRun) next_st.freqOut = 17'h00000;
    next_st.runInhibit = st.revLock && (reverseInchTerminal || (terminalCtrl && reverseRunTerminal));

    // fan state machine
    case (st.fanState)
      FAN_ON: begin
        next_st.fanOn = 1'b1;
        if (!running && st.fanMode == 1'b0) begin
          next_st.fanState = FAN_WAIT;
          next_st.fanCnt = 21'h000000;
        end
      end
      FAN_WAIT: begin
        if (running || st.fanMode) next_st.fanState = FAN_ON;
        else if (tick) begin
          next_st.fanCnt = st.fanCnt + 21'h000001;
          if (st.fanCnt == 21'(FAN_WAIT_P - 1)) next_st.fanState = FAN_TEMP;
        end
      end
      FAN_TEMP: begin
        if (running || st.fanMode) begin
          next_st.fanState = FAN_ON;
          next_st.fanOn = 1'b1;
        end else begin
          if (moduleTempC < 8'(FAN_TEMP_C)) next_st.fanOn = 1'b0;
          if (tick && st.fanCnt != 21'(FAN_LIMIT_P)) next_st.fanCnt = st.fanCnt + 21'h000001;
          if (st.fanCnt == 21'(FAN_LIMIT_P)) next_st.fanOn = 1'b0;
        end
      end
      default: next_st.fanState = FAN_ON;
    endcase
    if (st.fanMode) next_st.fanOn = 1'b1;

    // encoder loss detection and gear-corrected speed per tick
    next_st.encPrev = encoderPulse;
    if (!encoderUsed || (encoderPulse != st.encPrev)) begin
      next_st.lossCnt = 14'h0000;
      next_st.encLoss = 1'b0;
    end else if (tick && running) begin
      if (st.lossCnt > 14'(st.lossTime) * 14'd100) next_st.encLoss = 1'b1;
      else next_st.lossCnt = st.lossCnt + 14'h0001;
    end
    if (encoderPulse && !st.encPrev) next_st.pulseCnt = st.pulseCnt + 16'h0001;
    if (tick) begin
      next_st.pulseCnt = 16'(encoderPulse && !st.encPrev);
      next_st.geared = 24'((42'(st.pulseCnt) * 42'(st.encGear) * 42'd60000)
                       / (42'(st.motorGear) * 42'(st.ppr)));
    end

    // keypad remapping
    next_st.jogKeyPrev = jogKey;
    if (shiftKey && jogKey && functionGroupShown) begin
      if (tick && st.holdCnt != 14'(HOLD_P)) next_st.holdCnt = st.holdCnt + 14'h0001;
      if (st.holdCnt == 14'(HOLD_P)) next_st.updnHeld = 1'b1;
    end else begin
      next_st.holdCnt = 14'h0000;
    end
    next_st.upKey = updnOn && jogKey;
    next_st.dnKey = updnOn && runKey;
    next_st.runKeyOut = !updnOn && runKey;
    next_st.jogCmd = !updnOn && keypadMonitor && !st.jogRole && jogKey
                     && (st.jogPri || !running);
    next_st.dirToggle = !updnOn && keypadMonitor && st.jogRole && jogKey && !st.jogKeyPrev;

    // reset values
    if (sys_rst) begin
      next_st = '0;
      next_st.rampTime = {8{RAMP_RST}};
      next_st.abnTime = ABN_RST;
      next_st.mult = MULT_ONE;
      next_st.ppr = PPR_RST;
      next_st.lossTime = LOSS_RST;
      next_st.lossAct = LOSS_ACT_RST;
      next_st.motorGear = GEAR_RST;
      next_st.encGear = GEAR_RST;
      next_st.fanState = FAN_ON;
      next_st.fanOn = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // outputs straight from state
  assign regRdData      = st.rdData;
  assign freqStep       = st.freqStep;
  assign freqOut        = st.freqOut;
  assign phaseSwap      = st.phaseOrder;
  assign runInhibit     = st.runInhibit;
  assign fanOn          = st.fanOn;
  assign encoderLossAct = st.lossAct;
  assign encoderLoss    = st.encLoss;
  assign gearedSpeed    = st.geared;
  assign jogCmd         = st.jogCmd;
  assign dirToggle      = st.dirToggle;
  assign upKey          = st.upKey;
  assign decrementKey   = st.dnKey;
  assign runKeyOut      = st.runKeyOut;
endmodule
`default_nettype wire

/* drc_pkg.sv */
// constants and types shared by the drive ramp and direction control block
// Behaviour
// - three extra accel/decel time pairs 2..4, each 0.1 to 3600 s
// - terminals select active ramp pair while running; none active picks pair one
// - forced or abnormal stop decelerates with abnormal-stop time, stop mode still applies
// - sequence-program and jog runs ignore terminal ramp selection, use own times
// - ramp times scaled: 0 one times, 1 ten times, 2 one tenth
// - auto fan: run while operating, check temp 3 min after stop, off below 50 C or 30 min
// - fan mode 1 keeps fan running from power-up always
// - phase order 1 swaps output phases so forward turns other way
// - reverse lock with keypad reverse run gives zero output frequency
// - reverse lock refuses run on reverse jog terminal or terminal reverse run
// - encoder resolution setting 1 to 9999 pulses per revolution, default 1000
// - encoder loss past detection time applies action 0 dec,1 coast,2 abnormal,3 run
// - encoder speed corrected by encoder gear over motor gear teeth
// - jog key in monitoring: 0 jogs, 1 toggles direction per press
// - keypad up/down mode maps jog key to up and run key to down
// - shift plus jog held 5 s in function group enables up/down, not kept
// - frequency mode 0: 0.01 Hz to 400.00; mode 1: 0.1 Hz to 1000.0
// - opposite-direction output frequency capped by settable limit, default 0.00 Hz
// - jog priority 1 accepts jog stopped or running; 0 only when stopped
package drc_pkg;
  // clock and time base
  localparam int CLK_HZ        = 250_000_000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int FAN_WAIT_MIN  = 3;
  localparam int FAN_LIMIT_MIN = 30;
  localparam int FAN_WAIT_MS   = FAN_WAIT_MIN * 60_000;
  localparam int FAN_LIMIT_MS  = FAN_LIMIT_MIN * 60_000;
  localparam int HOLD_S        = 5;
  localparam int HOLD_MS       = HOLD_S * 1000;
  localparam int FAN_TEMP_C    = 50;
  // setting ranges and reset values (times in 0.1 s)
  localparam logic [15:0] RAMP_MIN        = 16'h0001;
  localparam logic [15:0] RAMP_MAX        = 16'h8CA0;
  localparam logic [15:0] RAMP_RST        = 16'h003C;
  localparam logic [15:0] ABN_RST         = 16'h001E;
  localparam logic [13:0] PPR_RST         = 14'h03E8;
  localparam logic [13:0] PPR_MAX         = 14'h270F;
  localparam logic [9:0]  GEAR_RST        = 10'h001;
  localparam logic [9:0]  GEAR_MAX        = 10'h3E8;
  localparam logic [6:0]  LOSS_RST        = 7'h14;
  localparam logic [6:0]  LOSS_MAX        = 7'h64;
  localparam logic [1:0]  LOSS_ACT_RST    = 2'h1;
  // full span in frequency units: 400.00 Hz at 0.01, 1000.0 Hz at 0.1
  localparam logic [16:0] SPAN_LOW        = 17'h09C40;
  localparam logic [16:0] SPAN_HIGH       = 17'h02710;
  // multiplier codes
  localparam logic [1:0]  MULT_ONE        = 2'h0;
  localparam logic [1:0]  MULT_TEN        = 2'h1;
  localparam logic [1:0]  MULT_TENTH      = 2'h2;
  // encoder loss actions
  localparam logic [1:0]  LOSS_DEC        = 2'h0;
  localparam logic [1:0]  LOSS_COAST      = 2'h1;
  localparam logic [1:0]  LOSS_ABN        = 2'h2;
  localparam logic [1:0]  LOSS_RUN        = 2'h3;
  // fan states, one-hot
  typedef enum logic [2:0] {
    FAN_ON   = 3'h1,
    FAN_WAIT = 3'h2,
    FAN_TEMP = 3'h4
  } drc_fan_type;
endpackage

/* drc_ramp_monitor.sv */
// assertion checker for the drive ramp and direction control block
`timescale 1ns/1ps
`default_nettype none
module drc_ramp_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // register port
  input wire logic [4:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  // commands and keys
  input wire logic        running,
  input wire logic        terminalCtrl,
  input wire logic        keypadRevRun,
  input wire logic        reverseInchTerminal,
  input wire logic        keypadMonitor,
  input wire logic        jogKey,
  // results
  input wire logic [16:0] freqOut,
  input wire logic        runInhibit,
  input wire logic        fanOn,
  input wire logic        jogCmd,
  input wire logic        dirToggle,
  input wire logic        upKey
);
  logic revLock, fanMode, jogPri, jogRole, upDn;
  // shadow of the settings the properties depend on, legal 0/1 writes only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {revLock, fanMode, jogPri, jogRole, upDn} <= 5'h00;
    end else if (regWr && regWrData[15:1] == 15'h0000) begin
      case (regAddr)
        5'h08: fanMode <= regWrData[0];
        5'h0A: revLock <= regWrData[0];
        5'h10: jogRole <= regWrData[0];
        5'h11: upDn <= regWrData[0];
        5'h14: jogPri <= regWrData[0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // drive stops; jog key pressed
  sequence s_stop; running ##1 !running; endsequence
  sequence s_press; !jogKey ##1 jogKey; endsequence
  a_rd_idle: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data not idle");
  a_inch_block: assert property (revLock && reverseInchTerminal |=> runInhibit)
    else $error("reverse jog not inhibited");
  a_key_zero: assert property (revLock && !terminalCtrl && keypadRevRun |=> freqOut == 17'h00000)
    else $error("keypad reverse not held at zero");
  a_fan_fixed: assert property (fanMode |=> fanOn)
    else $error("fan off in continuous mode");
  a_fan_run: assert property (running |=> fanOn)
    else $error("fan off while running");
  a_fan_wait: assert property (s_stop |-> fanOn [*8])
    else $error("fan stopped too soon after stop");
  a_jog_block: assert property (!jogPri && running |=> !jogCmd)
    else $error("jog taken while running");
  a_toggle_pulse: assert property (dirToggle |-> jogRole ##1 !dirToggle)
    else $error("direction toggle wrong");
  a_toggle_press: assert property ((jogRole && keypadMonitor && !upDn) ##0 s_press |=> dirToggle)
    else $error("press gave no toggle");
  a_up_map: assert property (upDn && jogKey |=> upKey)
    else $error("jog key not mapped to up");
endmodule
bind drc_ramp_control drc_ramp_monitor i_drc_ramp_monitor (.core_clk, .sys_rst, .regAddr, .regWrData,
  .regWr, .regRd, .regRdData, .running, .terminalCtrl, .keypadRevRun, .reverseInchTerminal, .keypadMonitor,
  .jogKey, .freqOut, .runInhibit, .fanOn, .jogCmd, .dirToggle, .upKey);
`default_nettype wire

/* drc_motor_model.sv */
// behavioural motor shaft encoder for the drive ramp control bench
`timescale 1ns/1ps
`default_nettype none
module drc_motor_model #(
  parameter int HALF_P = 8
) (
  // clock
  input  wire logic core_clk,
  // cable connected
  input  wire logic encOn,
  // encoder line
  output var logic  encoderPulse
);
  int cnt = 0;
  // toggle while connected; a cut cable leaves the pulled-up line high
  always @(posedge core_clk) begin
    cnt = (cnt + 1) % HALF_P;
    if (!encOn) begin
      encoderPulse <= 1'b1;
    end else if (cnt == 0) begin
      encoderPulse <= ~encoderPulse;
    end
  end
  initial encoderPulse = 1'b0;
endmodule
`default_nettype wire

/* drc_ramp_control_bench.sv */
// self-checking bench for the drive ramp and direction control block
`timescale 1ns/1ps
`default_nettype none
module drc_ramp_control_bench;
  import drc_pkg::*;
  // register row: write flag, index, data, expected read back
  typedef struct packed {logic w; logic [4:0] a; logic [15:0] d; logic [15:0] e;} drc_row_type;
  logic        core_clk, sys_rst, regWr, regRd, running, terminalCtrl, keypadRevRun, reverseRunTerminal;
  logic        reverseInchTerminal, forcedStop, abnormalStop, seqProgRun, jogRun, rampSelActive, decelerating;
  logic        cmdReverse, outReverse, encoderUsed, keypadMonitor, functionGroupShown, jogKey, runKey;
  logic        shiftKey, encOn, encoderPulse, phaseSwap, runInhibit, fanOn, encoderLoss, jogCmd, dirToggle;
  logic        upKey, decrementKey, runKeyOut;
  logic [4:0]  regAddr;
  logic [15:0] regWrData, regRdData, seqAccelTime, seqDecelTime, jogAccelTime, jogDecelTime;
  logic [1:0]  rampSelTerm, encoderLossAct;
  logic [16:0] freqTarget, freqStep, freqOut;
  logic [7:0]  moduleTempC;
  logic [23:0] gearedSpeed;
  int          n_fail = 0;
  int          check_count = 0;
  int          i;
  drc_row_type rows [20] = '{
    '{0,5'h00,16'h0,16'h003C}, '{0,5'h05,16'h0,16'h003C}, '{0,5'h06,16'h0,16'h001E}, '{0,5'h07,16'h0,16'h0},
    '{0,5'h0B,16'h0,16'h03E8}, '{0,5'h0C,16'h0,16'h0014}, '{0,5'h0D,16'h0,16'h0001}, '{0,5'h0E,16'h0,16'h1},
    '{0,5'h13,16'h0,16'h0000}, '{0,5'h16,16'h0,16'h003C}, '{1,5'h1F,16'h1234,16'h0}, '{1,5'h07,16'h3,16'h0},
    '{1,5'h0B,16'h0,16'h03E8}, '{1,5'h0B,16'h2710,16'h03E8}, '{1,5'h0B,16'h270F,16'h270F},
    '{1,5'h0E,16'h03E9,16'h1}, '{1,5'h0F,16'h03E8,16'h03E8}, '{1,5'h0C,16'h65,16'h14}, '{1,5'h01,16'h0,16'h1},
    '{1,5'h01,16'hFFFF,16'h8CA0}};
  drc_ramp_control #(.TICK_CYCLES_P(4), .FAN_WAIT_P(5), .FAN_LIMIT_P(10), .HOLD_P(5)) i_drc_ramp_control (
    .core_clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .running, .terminalCtrl,
    .keypadRevRun, .reverseRunTerminal, .reverseInchTerminal, .forcedStop, .abnormalStop, .seqProgRun, .jogRun,
    .seqAccelTime, .seqDecelTime, .jogAccelTime, .jogDecelTime, .rampSelTerm, .rampSelActive, .decelerating,
    .cmdReverse, .outReverse, .freqTarget, .moduleTempC, .encoderPulse, .encoderUsed, .keypadMonitor,
    .functionGroupShown, .jogKey, .runKey, .shiftKey, .freqStep, .freqOut, .phaseSwap, .runInhibit, .fanOn,
    .encoderLossAct, .encoderLoss, .gearedSpeed, .jogCmd, .dirToggle, .upKey, .decrementKey, .runKeyOut);
  drc_motor_model i_drc_motor_model (.core_clk, .encOn, .encoderPulse);
  // compare and count
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk("regRdData", {8'h00, e}, {8'h00, regRdData});
  endtask
  // ramp step for one mode set
  task automatic step(input logic [1:0] m, input logic s, input logic dn, input logic [1:0] ab,
                      input logic j, input logic q, input logic r, input logic [16:0] e);
    wr(5'h07, {14'h0000, m});
    wr(5'h12, {15'h0000, r});
    rampSelActive <= s;
    decelerating <= dn;
    {abnormalStop, forcedStop} <= ab;
    jogRun <= j;
    seqProgRun <= q;
    cyc(4);
    chk("freqStep", {7'h00, e}, {7'h00, freqStep});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // run limit
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    finish_test;
  end
  // main sequence
  initial begin
    {regWr, regRd, running, terminalCtrl, keypadRevRun, reverseRunTerminal, reverseInchTerminal, forcedStop,
     abnormalStop, seqProgRun, jogRun, rampSelActive, decelerating, cmdReverse, outReverse, functionGroupShown,
     jogKey, runKey, shiftKey, regAddr, regWrData} = '0;
    {sys_rst, encOn, encoderUsed, keypadMonitor} = 4'hF;
    {seqAccelTime, seqDecelTime, jogAccelTime, jogDecelTime} = {16'h0190, 16'h0064, 16'h00C8, 16'h0064};
    {rampSelTerm, freqTarget, moduleTempC} = {2'h1, 17'h003E8, 8'h3C};
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(1);
    chk("encoderLossAct", 24'h1, {22'h0, encoderLossAct});
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rd(rows[k].a, rows[k].e);
    end
    // fan: hot stop holds, cool stop ends early, mode 1 always on
    @(posedge core_clk);
    running <= 1'b1;
    cyc(5);
    chk("fanOn", 24'h1, {23'h0, fanOn});
    @(posedge core_clk);
    running <= 1'b0;
    cyc(30);
    chk("fanOn", 24'h1, {23'h0, fanOn});
    for (i = 0; i < 200 && fanOn !== 1'b0; i++) cyc(1);
    chk("fanOn", 24'h0, {23'h0, fanOn});
    @(posedge core_clk);
    {running, moduleTempC} <= {1'b1, 8'h28};
    cyc(5);
    @(posedge core_clk);
    running <= 1'b0;
    cyc(10);
    chk("fanOn", 24'h1, {23'h0, fanOn});
    for (i = 0; i < 40 && fanOn !== 1'b0; i++) cyc(1);
    chk("fanOn", 24'h0, {23'h0, fanOn});
    wr(5'h08, 16'h0001);
    cyc(100);
    chk("fanOn", 24'h1, {23'h0, fanOn});
    // ramp step per tick
    wr(5'h00, 16'h0064);
    wr(5'h01, 16'h0032);
    running <= 1'b1;
    step(2'h0, 1, 0, 2'h0, 0, 0, 0, 17'd4);
    step(2'h1, 1, 0, 2'h0, 0, 0, 0, 17'd1);
    step(2'h2, 1, 0, 2'h0, 0, 0, 0, 17'd40);
    step(2'h0, 0, 0, 2'h0, 0, 0, 0, 17'd7);
    step(2'h0, 1, 1, 2'h0, 0, 0, 0, 17'd8);
    step(2'h0, 1, 1, 2'h1, 0, 0, 0, 17'd14);
    step(2'h0, 1, 1, 2'h2, 0, 0, 0, 17'd14);
    step(2'h0, 1, 0, 2'h0, 1, 0, 0, 17'd2);
    step(2'h0, 1, 0, 2'h0, 0, 1, 0, 17'd1);
    step(2'h0, 1, 0, 2'h0, 0, 0, 1, 17'd1);
    step(2'h0, 1, 0, 2'h0, 0, 0, 0, 17'd4);
    // phase order, reverse lock and opposite cap
    wr(5'h09, 16'h0001);
    wr(5'h0A, 16'h0001);
    {reverseInchTerminal, keypadRevRun} <= 2'h3;
    cyc(3);
    chk("phaseSwap", 24'h1, {23'h0, phaseSwap});
    chk("runInhibit", 24'h1, {23'h0, runInhibit});
    chk("freqOut", 24'h0, {7'h0, freqOut});
    @(posedge core_clk);
    {reverseInchTerminal, keypadRevRun, terminalCtrl, reverseRunTerminal} <= 4'h3;
    cyc(3);
    chk("runInhibit", 24'h1, {23'h0, runInhibit});
    wr(5'h0A, 16'h0000);
    {terminalCtrl, reverseRunTerminal, outReverse} <= 3'h1;
    cyc(3);
    chk("runInhibit", 24'h0, {23'h0, runInhibit});
    chk("freqOut", 24'h0, {7'h0, freqOut});
    wr(5'h13, 16'h01F4);
    cyc(3);
    chk("freqOut", 24'h1F4, {7'h0, freqOut});
    @(posedge core_clk);
    cmdReverse <= 1'b1;
    cyc(3);
    chk("freqOut", 24'h3E8, {7'h0, freqOut});
    // encoder loss after 0.1 s without edges
    wr(5'h0C, 16'h0001);
    for (i = 0; i < 4; i++) begin
      wr(5'h0D, 16'(i));
      cyc(3);
      chk("encoderLossAct", 24'(i), {22'h0, encoderLossAct});
    end
    encOn <= 1'b0;
    cyc(300);
    chk("encoderLoss", 24'h0, {23'h0, encoderLoss});
    for (i = 0; i < 300 && encoderLoss !== 1'b1; i++) cyc(1);
    chk("encoderLoss", 24'h1, {23'h0, encoderLoss});
    // jog key roles, priority, up/down
    @(posedge core_clk);
    {encOn, jogKey} <= 2'h3;
    cyc(3);
    chk("jogCmd", 24'h0, {23'h0, jogCmd});
    wr(5'h14, 16'h0001);
    cyc(3);
    chk("jogCmd", 24'h1, {23'h0, jogCmd});
    for (i = 0; i < 40 && gearedSpeed === 0; i++) cyc(1);
    chk("gearedSpeed", 24'h1770, gearedSpeed);
    wr(5'h10, 16'h0001);
    jogKey <= 1'b0;
    cyc(3);
    @(posedge core_clk);
    jogKey <= 1'b1;
    cyc(2);
    chk("dirToggle", 24'h1, {23'h0, dirToggle});
    wr(5'h10, 16'h0000);
    wr(5'h11, 16'h0001);
    {jogKey, runKey} <= 2'h3;
    cyc(3);
    chk("upDownKeys", 24'h6, {21'h0, upKey, decrementKey, runKeyOut});
    wr(5'h11, 16'h0000);
    wr(5'h14, 16'h0000);
    {runKey, functionGroupShown, shiftKey, jogKey} <= 4'h7;
    cyc(40);
    rd(5'h11, 16'h0001);
    finish_test;
  end
endmodule
`default_nettype wire
